// ==== byte_alu_cfg.svh ====
// Constants of the byte ALU: flag positions, reset values, register map
`ifndef BYTE_ALU_CFG_SVH
`define BYTE_ALU_CFG_SVH
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAGS_RST 8'h00
`define RESULT_RST 16'h0000
`define COUNT_RST 32'h0000_0000
`define BYTE_ALL_ONES 8'hFF
`define REG_FLAGS 8'h00
`define REG_RESULT 8'h04
`define REG_COUNT 8'h08
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`define WORD_IMM_W 6
`endif

// ==== byte_alu_pkg.sv ====
// Types of the byte ALU: operation select and sequencer states
package byte_alu_pkg;
    typedef enum logic [4:0] {
        OP_ADD, OP_ADD_CARRY, OP_ADD_IMM_WORD, OP_SUB, OP_SUB_IMM, OP_SUB_REGS_BORROW,
        OP_SUB_IMM_BORROW, OP_SUB_IMM_WORD, OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM,
        OP_XOR_REGS, OP_ONES_COMPLEMENT, OP_TWOS_COMPLEMENT, OP_SET_MASK_BITS,
        OP_CLEAR_MASK_BITS, OP_INCREMENT, OP_DECREMENT_REG, OP_TEST_REG, OP_ZERO_REG,
        OP_ALL_ONES_REG
    } alu_op_t;
    typedef enum logic [0:0] {ST_IDLE, ST_WORD_TAIL} seq_state_t;
endpackage

// ==== byte_alu_core.sv ====
// Combinational result and flag computation of the byte ALU
`timescale 1ns/1ps
`default_nettype none
`include "byte_alu_cfg.svh"
module byte_alu_core (
    input wire byte_alu_pkg::alu_op_t op_i,
    input wire logic [7:0] dst_i,
    input wire logic [7:0] dst_hi_i,
    input wire logic [7:0] src_i,
    input wire logic [7:0] imm_i,
    input wire logic [7:0] flags_i,
    output logic [15:0] res_o,
    output logic [7:0] flags_o,
    output logic [7:0] flag_wr_o
);
    // Half carry, overflow and carry of an 8-bit add or subtract
    function automatic logic [2:0] hvc(input logic [7:0] a, input logic [7:0] b,
                                       input logic [7:0] r, input logic sub);
        logic h;
        logic v;
        logic c;
        if (sub) begin
            h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
            v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
            c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
        end else begin
            h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
            v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
            c = (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]);
        end
        return {h, v, c};
    endfunction

    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] r;
    logic [15:0] w;
    logic [15:0] kw;
    logic [2:0] f;
    logic cin;
    logic sub;
    logic chain_z;

    // One adder serves every byte op; logic ops, increment and decrement override its result
    always_comb begin
        a = dst_i;
        b = 8'h00;
        cin = 1'b0;
        sub = 1'b0;
        chain_z = 1'b0;
        flags_o = flags_i;
        flag_wr_o = 8'h00;
        kw = {10'h000, imm_i[`WORD_IMM_W-1:0]};
        w = {dst_hi_i, dst_i};
        case (op_i)
            byte_alu_pkg::OP_ADD_CARRY: begin b = src_i; cin = flags_i[`FLAG_C]; end
            byte_alu_pkg::OP_SUB: begin b = src_i; sub = 1'b1; end
            byte_alu_pkg::OP_SUB_IMM: begin b = imm_i; sub = 1'b1; end
            byte_alu_pkg::OP_SUB_REGS_BORROW: begin
                b = src_i;
                sub = 1'b1;
                cin = flags_i[`FLAG_C];
                chain_z = 1'b1;
            end
            byte_alu_pkg::OP_SUB_IMM_BORROW: begin
                b = imm_i;
                sub = 1'b1;
                cin = flags_i[`FLAG_C];
                chain_z = 1'b1;
            end
            byte_alu_pkg::OP_TWOS_COMPLEMENT: begin a = 8'h00; b = dst_i; sub = 1'b1; end
            default: b = src_i;
        endcase
        r = sub ? 8'(a - b - {7'h00, cin}) : 8'(a + b + {7'h00, cin});
        f = hvc(a, b, r, sub);
        case (op_i)
            byte_alu_pkg::OP_ADD, byte_alu_pkg::OP_ADD_CARRY, byte_alu_pkg::OP_SUB,
            byte_alu_pkg::OP_SUB_IMM, byte_alu_pkg::OP_SUB_REGS_BORROW,
            byte_alu_pkg::OP_SUB_IMM_BORROW, byte_alu_pkg::OP_TWOS_COMPLEMENT: begin
                flags_o[`FLAG_H] = f[2];
                flags_o[`FLAG_V] = f[1];
                flags_o[`FLAG_C] = f[0];
                flag_wr_o = 8'h2F;
            end
            byte_alu_pkg::OP_ADD_IMM_WORD, byte_alu_pkg::OP_SUB_IMM_WORD: begin
                flag_wr_o = 8'h1F;
            end
            byte_alu_pkg::OP_ALL_ONES_REG: flag_wr_o = 8'h00;
            default: begin
                flags_o[`FLAG_V] = 1'b0;
                flag_wr_o = 8'h0E;
            end
        endcase
        case (op_i)
            byte_alu_pkg::OP_AND: r = dst_i & src_i;
            byte_alu_pkg::OP_AND_IMM: r = dst_i & imm_i;
            byte_alu_pkg::OP_OR: r = dst_i | src_i;
            byte_alu_pkg::OP_OR_IMM, byte_alu_pkg::OP_SET_MASK_BITS: r = dst_i | imm_i;
            byte_alu_pkg::OP_XOR_REGS: r = dst_i ^ src_i;
            byte_alu_pkg::OP_CLEAR_MASK_BITS: r = dst_i & (`BYTE_ALL_ONES - imm_i);
            byte_alu_pkg::OP_TEST_REG: r = dst_i & dst_i;
            byte_alu_pkg::OP_ZERO_REG: r = dst_i ^ dst_i;
            byte_alu_pkg::OP_ALL_ONES_REG: r = `BYTE_ALL_ONES;
            byte_alu_pkg::OP_ONES_COMPLEMENT: begin
                r = `BYTE_ALL_ONES - dst_i;
                flags_o[`FLAG_C] = 1'b1;
                flag_wr_o = 8'h0F;
            end
            byte_alu_pkg::OP_INCREMENT: begin
                r = 8'(dst_i + 8'h01);
                flags_o[`FLAG_V] = (r == 8'h80);
            end
            byte_alu_pkg::OP_DECREMENT_REG: begin
                r = 8'(dst_i - 8'h01);
                flags_o[`FLAG_V] = (r == 8'h7F);
            end
            default: r = r;
        endcase
        // Borrow chains keep zero only if every earlier byte was zero too
        flags_o[`FLAG_Z] = (r == 8'h00) & (~chain_z | flags_i[`FLAG_Z]);
        flags_o[`FLAG_N] = r[7];
        res_o = {8'h00, r};
        if (op_i == byte_alu_pkg::OP_ADD_IMM_WORD || op_i == byte_alu_pkg::OP_SUB_IMM_WORD) begin
            w = (op_i == byte_alu_pkg::OP_SUB_IMM_WORD) ? 16'(w - kw) : 16'(w + kw);
            res_o = w;
            flags_o[`FLAG_Z] = (w == 16'h0000);
            flags_o[`FLAG_N] = w[15];
            if (op_i == byte_alu_pkg::OP_SUB_IMM_WORD) begin
                flags_o[`FLAG_V] = dst_hi_i[7] & ~w[15];
                flags_o[`FLAG_C] = w[15] & ~dst_hi_i[7];
            end else begin
                flags_o[`FLAG_V] = ~dst_hi_i[7] & w[15];
                flags_o[`FLAG_C] = ~w[15] & dst_hi_i[7];
            end
            flags_o[`FLAG_S] = flags_o[`FLAG_N] ^ flags_o[`FLAG_V];
        end
    end
endmodule
`default_nettype wire

// ==== byte_alu_axil.sv ====
// AXI4-Lite slave front end: one read and up to two writes in flight
`timescale 1ns/1ps
`default_nettype none
`include "byte_alu_cfg.svh"
module byte_alu_axil #(
    parameter int ADDR_W = 8
) (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic [ADDR_W-1:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [ADDR_W-1:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    output logic wr_en_o,
    output logic [ADDR_W-1:0] wr_addr_o,
    output logic [31:0] wr_data_o,
    output logic [3:0] wr_strb_o,
    input wire logic wr_err_i,
    output logic [ADDR_W-1:0] rd_addr_o,
    input wire logic [31:0] rd_data_i,
    input wire logic rd_err_i
);
    logic aw_r, aw_nxt, w_r, w_nxt, awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt;
    logic bv_r, bv_nxt, arrdy_r, arrdy_nxt, rv_r, rv_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [31:0] data_r, data_nxt, rdata_r, rdata_nxt;
    logic [3:0] strb_r, strb_nxt;

    assign wr_en_o = aw_r & w_r & ~bv_r;
    assign wr_addr_o = addr_r;
    assign wr_data_o = data_r;
    assign wr_strb_o = strb_r;
    assign rd_addr_o = araddr_i;

    // Address and data are latched apart, so either may come first
    always_comb begin
        aw_nxt = aw_r;
        w_nxt = w_r;
        addr_nxt = addr_r;
        data_nxt = data_r;
        strb_nxt = strb_r;
        bv_nxt = bv_r;
        bresp_nxt = bresp_r;
        rv_nxt = rv_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (bv_r && bready_i) bv_nxt = 1'b0;
        if (wr_en_o) begin
            aw_nxt = 1'b0;
            w_nxt = 1'b0;
            bv_nxt = 1'b1;
            bresp_nxt = wr_err_i ? `AXI_SLVERR : `AXI_OKAY;
        end
        if (awvalid_i && awrdy_r) begin aw_nxt = 1'b1; addr_nxt = awaddr_i; end
        if (wvalid_i && wrdy_r) begin w_nxt = 1'b1; data_nxt = wdata_i; strb_nxt = wstrb_i; end
        if (rv_r && rready_i) rv_nxt = 1'b0;
        if (arvalid_i && arrdy_r) begin
            rv_nxt = 1'b1;
            rdata_nxt = rd_data_i;
            rresp_nxt = rd_err_i ? `AXI_SLVERR : `AXI_OKAY;
        end
        awrdy_nxt = ~aw_nxt;
        wrdy_nxt = ~w_nxt;
        arrdy_nxt = ~rv_nxt;
    end

    // Handshake state registers
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            aw_r <= 1'b0;
            w_r <= 1'b0;
            awrdy_r <= 1'b0;
            wrdy_r <= 1'b0;
            arrdy_r <= 1'b0;
            bv_r <= 1'b0;
            rv_r <= 1'b0;
            bresp_r <= `AXI_OKAY;
            rresp_r <= `AXI_OKAY;
            addr_r <= '0;
            data_r <= 32'h0000_0000;
            strb_r <= 4'h0;
            rdata_r <= 32'h0000_0000;
        end else begin
            aw_r <= aw_nxt;
            w_r <= w_nxt;
            awrdy_r <= awrdy_nxt;
            wrdy_r <= wrdy_nxt;
            arrdy_r <= arrdy_nxt;
            bv_r <= bv_nxt;
            rv_r <= rv_nxt;
            bresp_r <= bresp_nxt;
            rresp_r <= rresp_nxt;
            addr_r <= addr_nxt;
            data_r <= data_nxt;
            strb_r <= strb_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign awready_o = awrdy_r;
    assign wready_o = wrdy_r;
    assign bvalid_o = bv_r;
    assign bresp_o = bresp_r;
    assign arready_o = arrdy_r;
    assign rvalid_o = rv_r;
    assign rresp_o = rresp_r;
    assign rdata_o = rdata_r;
endmodule
`default_nettype wire

// ==== byte_alu_arith_logic.sv ====
// Byte ALU top: operation sequencer, status flags and register access
//
// Operation
// - Add source to destination, with carry in for the carry form, flags Z C N V H, one cycle.
// - Add a small immediate to a register pair, flags Z C N V S, two cycles.
// - Subtract source or immediate from destination, flags Z C N V H, one cycle.
// - Subtract source and carry from destination, flags Z C N V H, one cycle.
// - Subtract immediate and carry from destination, flags Z C N V H, one cycle.
// - Subtract a small immediate from a register pair, flags Z C N V S, two cycles.
// - AND destination with source or immediate, flags Z N V only, one cycle.
// - OR or XOR with source, or OR with immediate, flags Z N V, one cycle.
// - Set the bits of an immediate mask in the destination, flags Z N V, one cycle.
// - Clear mask bits by ANDing with all ones minus the mask, flags Z N V, one cycle.
// - Test a register by ANDing it with itself, value kept, flags Z N V, one cycle.
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "byte_alu_cfg.svh"
module byte_alu_arith_logic #(
    parameter int ADDR_W = 8
) (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic op_valid_i,
    input wire byte_alu_pkg::alu_op_t op_i,
    input wire logic [7:0] dst_i,
    input wire logic [7:0] dst_hi_i,
    input wire logic [7:0] src_i,
    input wire logic [7:0] imm_i,
    output logic busy_o,
    output logic res_valid_o,
    output logic [15:0] res_o,
    output logic [7:0] flags_o,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    // Register map decode, shared by the read and write paths
    function automatic logic [1:0] decode(input logic [ADDR_W-1:0] addr);
        logic [1:0] sel;
        sel = 2'h3;
        if (addr == ADDR_W'(`REG_FLAGS)) sel = 2'h0;
        if (addr == ADDR_W'(`REG_RESULT)) sel = 2'h1;
        if (addr == ADDR_W'(`REG_COUNT)) sel = 2'h2;
        return sel;
    endfunction

    byte_alu_pkg::seq_state_t st_r, st_nxt;
    logic [7:0] flags_r, flags_nxt, pend_flags_r, pend_flags_nxt, pend_mask_r, pend_mask_nxt;
    logic [15:0] res_r, res_nxt, pend_res_r, pend_res_nxt;
    logic [31:0] count_r, count_nxt;
    logic busy_r, busy_nxt, res_valid_r, res_valid_nxt;
    logic [15:0] core_res;
    logic [7:0] core_flags, core_mask;
    logic accept, is_word, sw_flags_wr;
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data;
    logic [3:0] wr_strb;
    logic wr_err, rd_err;

    byte_alu_core u_core (
        .op_i(op_i),
        .dst_i(dst_i),
        .dst_hi_i(dst_hi_i),
        .src_i(src_i),
        .imm_i(imm_i),
        .flags_i(flags_r),
        .res_o(core_res),
        .flags_o(core_flags),
        .flag_wr_o(core_mask)
    );

    byte_alu_axil #(.ADDR_W(ADDR_W)) u_axil (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .awaddr_i(s_axi_awaddr_i),
        .awvalid_i(s_axi_awvalid_i),
        .awready_o(s_axi_awready_o),
        .wdata_i(s_axi_wdata_i),
        .wstrb_i(s_axi_wstrb_i),
        .wvalid_i(s_axi_wvalid_i),
        .wready_o(s_axi_wready_o),
        .bresp_o(s_axi_bresp_o),
        .bvalid_o(s_axi_bvalid_o),
        .bready_i(s_axi_bready_i),
        .araddr_i(s_axi_araddr_i),
        .arvalid_i(s_axi_arvalid_i),
        .arready_o(s_axi_arready_o),
        .rdata_o(s_axi_rdata_o),
        .rresp_o(s_axi_rresp_o),
        .rvalid_o(s_axi_rvalid_o),
        .rready_i(s_axi_rready_i),
        .wr_en_o(wr_en),
        .wr_addr_o(wr_addr),
        .wr_data_o(wr_data),
        .wr_strb_o(wr_strb),
        .wr_err_i(wr_err),
        .rd_addr_o(rd_addr),
        .rd_data_i(rd_data),
        .rd_err_i(rd_err)
    );

    // Read mux; result and count are read-only, writes to them are dropped
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        case (decode(rd_addr))
            2'h0: rd_data = {24'h00_0000, flags_r};
            2'h1: rd_data = {16'h0000, res_r};
            2'h2: rd_data = count_r;
            default: rd_err = 1'b1;
        endcase
    end

    assign wr_err = (decode(wr_addr) == 2'h3);
    assign sw_flags_wr = wr_en && (decode(wr_addr) == 2'h0) && wr_strb[0];
    assign accept = op_valid_i && (st_r == byte_alu_pkg::ST_IDLE);
    assign is_word = (op_i == byte_alu_pkg::OP_ADD_IMM_WORD) ||
                     (op_i == byte_alu_pkg::OP_SUB_IMM_WORD);

    // Sequencer: byte ops retire at the next edge, word ops one edge later
    always_comb begin
        st_nxt = st_r;
        flags_nxt = flags_r;
        res_nxt = res_r;
        count_nxt = count_r;
        busy_nxt = 1'b0;
        res_valid_nxt = 1'b0;
        pend_res_nxt = pend_res_r;
        pend_flags_nxt = pend_flags_r;
        pend_mask_nxt = pend_mask_r;
        // Software write first, so a retiring op wins on the bits it owns
        if (sw_flags_wr) flags_nxt = wr_data[7:0];
        case (st_r)
            byte_alu_pkg::ST_IDLE: begin
                if (accept && !is_word) begin
                    flags_nxt = (flags_nxt & ~core_mask) | (core_flags & core_mask);
                    res_nxt = core_res;
                    res_valid_nxt = 1'b1;
                    count_nxt = count_r + 32'h1;
                end else if (accept) begin
                    pend_res_nxt = core_res;
                    pend_flags_nxt = core_flags;
                    pend_mask_nxt = core_mask;
                    busy_nxt = 1'b1;
                    st_nxt = byte_alu_pkg::ST_WORD_TAIL;
                end
            end
            byte_alu_pkg::ST_WORD_TAIL: begin
                flags_nxt = (flags_nxt & ~pend_mask_r) | (pend_flags_r & pend_mask_r);
                res_nxt = pend_res_r;
                res_valid_nxt = 1'b1;
                count_nxt = count_r + 32'h1;
                st_nxt = byte_alu_pkg::ST_IDLE;
            end
            default: st_nxt = byte_alu_pkg::ST_IDLE;
        endcase
    end

    // Sequencer and flag registers
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            st_r <= byte_alu_pkg::ST_IDLE;
            flags_r <= `FLAGS_RST;
            res_r <= `RESULT_RST;
            count_r <= `COUNT_RST;
            busy_r <= 1'b0;
            res_valid_r <= 1'b0;
            pend_res_r <= `RESULT_RST;
            pend_flags_r <= `FLAGS_RST;
            pend_mask_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            flags_r <= flags_nxt;
            res_r <= res_nxt;
            count_r <= count_nxt;
            busy_r <= busy_nxt;
            res_valid_r <= res_valid_nxt;
            pend_res_r <= pend_res_nxt;
            pend_flags_r <= pend_flags_nxt;
            pend_mask_r <= pend_mask_nxt;
        end
    end

    assign busy_o = busy_r;
    assign res_valid_o = res_valid_r;
    assign res_o = res_r;
    assign flags_o = flags_r;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (srst_i);

    a_byte_add_sum: assert property (
        accept && op_i == byte_alu_pkg::OP_ADD_CARRY |=> res_valid_r &&
        res_r[7:0] == 8'($past(dst_i) + $past(src_i) + {7'h00, $past(flags_r[`FLAG_C])}))
        else $error("add with carry result wrong");
    a_word_add_two: assert property (
        accept && op_i == byte_alu_pkg::OP_ADD_IMM_WORD |=> busy_r && !res_valid_r ##1
        res_valid_r && res_r == 16'({$past(dst_hi_i, 2), $past(dst_i, 2)} +
        {10'h000, $past(imm_i[5:0], 2)}))
        else $error("word add late or wrong");
    a_sub_imm_diff: assert property (
        accept && op_i == byte_alu_pkg::OP_SUB_IMM |=>
        res_r[7:0] == 8'($past(dst_i) - $past(imm_i)) && res_valid_r)
        else $error("subtract immediate wrong");
    a_sub_borrow_reg: assert property (
        accept && op_i == byte_alu_pkg::OP_SUB_REGS_BORROW |=>
        res_r[7:0] == 8'($past(dst_i) - $past(src_i) - {7'h00, $past(flags_r[`FLAG_C])}))
        else $error("register borrow subtract wrong");
    a_sub_borrow_imm: assert property (
        accept && op_i == byte_alu_pkg::OP_SUB_IMM_BORROW |=>
        res_r[7:0] == 8'($past(dst_i) - $past(imm_i) - {7'h00, $past(flags_r[`FLAG_C])}))
        else $error("immediate borrow subtract wrong");
    a_word_sub_flags: assert property (
        accept && op_i == byte_alu_pkg::OP_SUB_IMM_WORD |=> ##1
        flags_r[`FLAG_S] == (flags_r[`FLAG_N] ^ flags_r[`FLAG_V]) &&
        flags_r[`FLAG_Z] == (res_r == 16'h0000) && res_valid_r)
        else $error("word subtract flags wrong");
    a_and_keep_carry: assert property (
        accept && op_i == byte_alu_pkg::OP_AND_IMM && !sw_flags_wr |=>
        !flags_r[`FLAG_V] && flags_r[`FLAG_C] == $past(flags_r[`FLAG_C]) &&
        res_r[7:0] == ($past(dst_i) & $past(imm_i)))
        else $error("and immediate wrong");
    a_xor_result: assert property (
        accept && op_i == byte_alu_pkg::OP_XOR_REGS |=>
        res_r[7:0] == ($past(dst_i) ^ $past(src_i)) && flags_r[`FLAG_N] == res_r[7])
        else $error("xor result wrong");
    a_mask_set: assert property (
        accept && op_i == byte_alu_pkg::OP_SET_MASK_BITS |=>
        res_r[7:0] == ($past(dst_i) | $past(imm_i)))
        else $error("set mask bits wrong");
    a_mask_clear: assert property (
        accept && op_i == byte_alu_pkg::OP_CLEAR_MASK_BITS |=>
        res_r[7:0] == ($past(dst_i) & ~$past(imm_i)) && !flags_r[`FLAG_V])
        else $error("clear mask bits wrong");
    a_test_keeps: assert property (
        accept && op_i == byte_alu_pkg::OP_TEST_REG |=>
        res_r[7:0] == $past(dst_i) && flags_r[`FLAG_Z] == ($past(dst_i) == 8'h00))
        else $error("test register wrong");
    a_all_ones_quiet: assert property (
        accept && op_i == byte_alu_pkg::OP_ALL_ONES_REG && !sw_flags_wr |=>
        flags_r == $past(flags_r) && res_r[7:0] == 8'hFF)
        else $error("set register touched flags");
    a_logic_keep_h: assert property (
        accept && !is_word && op_i == byte_alu_pkg::OP_OR && !sw_flags_wr |=>
        flags_r[`FLAG_H] == $past(flags_r[`FLAG_H]) && flags_r[`FLAG_S] == $past(flags_r[`FLAG_S]))
        else $error("unlisted flag changed");
endmodule
`default_nettype wire

// ==== byte_alu_op_src.sv ====
// Decoder-side model: raises one operation request while the sequencer is idle
`timescale 1ns/1ps
`default_nettype none
module byte_alu_op_src (
    input wire logic mclk_i,
    input wire logic go_i,
    input wire logic busy_i,
    output logic op_valid_o
);
    // Held back while busy, since a request then would be dropped silently
    always_ff @(posedge mclk_i) begin
        op_valid_o <= go_i && !busy_i;
    end
endmodule
`default_nettype wire

// ==== byte_alu_arith_logic_tb.sv ====
// Self-checking bench of the byte ALU: operation port and register access
`timescale 1ns/1ps
`default_nettype none
module byte_alu_arith_logic_tb;
    logic mclk_i = 1'h0;
    logic srst_i = 1'h1;
    logic go = 1'h0;
    logic op_valid_i, busy_o, res_valid_o, s_axi_awready_o, s_axi_wready_o;
    logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
    logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
    logic [7:0] dst_i = 8'h0, dst_hi_i = 8'h0, src_i = 8'h0, imm_i = 8'h0, flags_o;
    logic [7:0] s_axi_awaddr_i = 8'h0, s_axi_araddr_i = 8'h0;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
    logic [3:0] s_axi_wstrb_i = 4'hF;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [15:0] res_o;
    byte_alu_pkg::alu_op_t op_i = byte_alu_pkg::OP_ADD;
    int failures = 0;
    int n_compared = 0;
    always #10 mclk_i = ~mclk_i;
    byte_alu_arith_logic byte_alu_arith_logic_i (.mclk_i, .srst_i, .op_valid_i, .op_i, .dst_i,
        .dst_hi_i, .src_i, .imm_i, .busy_o, .res_valid_o, .res_o, .flags_o, .s_axi_awaddr_i,
        .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
        .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
        .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
        .s_axi_rready_i);
    byte_alu_op_src byte_alu_op_src_i (.mclk_i, .go_i(go), .busy_i(busy_o),
        .op_valid_o(op_valid_i));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One request; latency counted from the accepting edge
    task automatic run_op(input byte_alu_pkg::alu_op_t o, input logic [7:0] d, dh, s, i,
                          input int lat, input logic [15:0] er, input logic [7:0] ef);
        int n = 0;
        int nb = 0;
        @(posedge mclk_i);
        op_i <= o;
        dst_i <= d;
        dst_hi_i <= dh;
        src_i <= s;
        imm_i <= i;
        go <= 1'h1;
        @(posedge mclk_i);
        go <= 1'h0;
        do begin
            @(posedge mclk_i);
            #1;
            n++;
            if (busy_o === 1'h1) nb++;
        end while (res_valid_o !== 1'h1 && n < 8);
        chk(n, lat);
        chk(nb, lat - 1);
        chk(res_o, er);
        chk(flags_o, ef);
    endtask
    // Address and data offered together, each dropped once taken
    // Ready and valid read 1 ns after an edge, so they are what the next edge sees
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        logic aw_hs, w_hs, done;
        @(posedge mclk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'h1;
        s_axi_wvalid_i <= 1'h1;
        s_axi_bready_i <= 1'h1;
        do begin
            #1;
            aw_hs = s_axi_awvalid_i && s_axi_awready_o;
            w_hs = s_axi_wvalid_i && s_axi_wready_o;
            done = (s_axi_bvalid_o === 1'h1);
            @(posedge mclk_i);
            n++;
            if (aw_hs) s_axi_awvalid_i <= 1'h0;
            if (w_hs) s_axi_wvalid_i <= 1'h0;
        end while (!done && n < 20);
        s_axi_bready_i <= 1'h0;
        chk(done, 1'h1);
        chk(s_axi_bresp_o, 2'h0);
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n = 0;
        logic ar_hs, done;
        @(posedge mclk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'h1;
        s_axi_rready_i <= 1'h1;
        do begin
            #1;
            ar_hs = s_axi_arvalid_i && s_axi_arready_o;
            done = (s_axi_rvalid_o === 1'h1);
            @(posedge mclk_i);
            n++;
            if (ar_hs) s_axi_arvalid_i <= 1'h0;
        end while (!done && n < 20);
        s_axi_rready_i <= 1'h0;
        chk(done, 1'h1);
        chk(s_axi_rresp_o, er);
        if (er === 2'h0) chk(s_axi_rdata_o, ed);
    endtask
    task automatic t_arith;
        run_op(byte_alu_pkg::OP_ADD, 8'h80, 8'h0, 8'h80, 8'h0, 1, 16'h0, 8'h0B);
        run_op(byte_alu_pkg::OP_AND, 8'hF0, 8'h0, 8'h0F, 8'h0, 1, 16'h0, 8'h03);
        run_op(byte_alu_pkg::OP_ADD_CARRY, 8'h0F, 8'h0, 8'h0, 8'h0, 1, 16'h10, 8'h20);
        run_op(byte_alu_pkg::OP_SUB, 8'h0, 8'h0, 8'h01, 8'h0, 1, 16'hFF, 8'h25);
    endtask
    // Word forms keep the half-carry untouched
    task automatic t_word;
        run_op(byte_alu_pkg::OP_ADD_IMM_WORD, 8'hFF, 8'h0, 8'h0, 8'h01, 2, 16'h100, 8'h20);
        run_op(byte_alu_pkg::OP_SUB_IMM_WORD, 8'h0, 8'h0, 8'h0, 8'h01, 2, 16'hFFFF, 8'h35);
    endtask
    task automatic t_logic;
        run_op(byte_alu_pkg::OP_ALL_ONES_REG, 8'h5A, 8'h0, 8'h0, 8'h0, 1, 16'hFF, 8'h35);
        run_op(byte_alu_pkg::OP_CLEAR_MASK_BITS, 8'hFF, 8'h0, 8'h0, 8'hFF, 1, 16'h0, 8'h33);
    endtask
    // Borrow chain, bit ops and one-operand forms; storage bits 7:6 stay set
    task automatic t_more;
        run_op(byte_alu_pkg::OP_SUB_IMM, 8'h10, 8'h0, 8'h0, 8'h1, 1, 16'hF, 8'hE0);
        run_op(byte_alu_pkg::OP_ONES_COMPLEMENT, 8'hF, 8'h0, 8'h0, 8'h0, 1, 16'hF0,
            8'hE5);
        run_op(byte_alu_pkg::OP_SUB_IMM_BORROW, 8'h5, 8'h0, 8'h0, 8'h2, 1, 16'h2,
            8'hC0);
        run_op(byte_alu_pkg::OP_SUB_REGS_BORROW, 8'h0, 8'h0, 8'h0, 8'h0, 1, 16'h0,
            8'hC0);
        run_op(byte_alu_pkg::OP_XOR_REGS, 8'hF0, 8'h0, 8'h0F, 8'h0, 1, 16'hFF, 8'hC4);
        run_op(byte_alu_pkg::OP_TEST_REG, 8'h0, 8'h0, 8'h0, 8'h0, 1, 16'h0, 8'hC2);
        run_op(byte_alu_pkg::OP_INCREMENT, 8'h7F, 8'h0, 8'h0, 8'h0, 1, 16'h80, 8'hCC);
        run_op(byte_alu_pkg::OP_SET_MASK_BITS, 8'h1, 8'h0, 8'h0, 8'h80, 1, 16'h81,
            8'hC4);
    endtask
    // Flag register readback, storage bits, read-only and unmapped places
    task automatic t_regs;
        axi_rd(8'h00, 32'h33, 2'h0);
        axi_rd(8'h08, 32'h8, 2'h0);
        axi_wr(8'h00, 32'hC0);
        axi_rd(8'h00, 32'hC0, 2'h0);
        axi_wr(8'h04, 32'hAB);
        axi_rd(8'h04, 32'h0, 2'h0);
        axi_rd(8'h0C, 32'h0, 2'h2);
    endtask
    task automatic end_of_test;
        if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge mclk_i);
        srst_i <= 1'h0;
        @(posedge mclk_i);
        chk({busy_o, res_valid_o, res_o, flags_o}, 26'h0);
        t_arith;
        t_word;
        t_logic;
        t_regs;
        t_more;
        end_of_test;
    end
    // Run needs under a hundred cycles; far beyond that means a hang
    initial begin
        #100000;
        failures++;
        end_of_test;
    end
endmodule
`default_nettype wire
